// file: cfsf_defs.svh
// Constants for the configuration stream front end: markers, headers and command codes.
// Assumes inclusion by the package and by every design file that needs a figure.
// Behaviour
// - Serial modes never act on width marker words before the sync word.
// - Width detection looks only at the least significant byte lane.
// - Marker 0xBB followed by 0x11 on the low lane selects an 8-bit bus.
// - Marker 0xBB followed by 0x22 selects 16 bits; upper lanes ignored.
// - Marker 0xBB followed by 0x44 selects 32 bits; upper lanes ignored.
// - Any other byte after 0xBB returns detection to hunting for 0xBB; here a repeated 0xBB keeps the marker armed.
// - A valid pair fixes the port width, then the sync hunt begins.
// - Width stays fixed until power cycle, program pulse, or reprogram events.
// - Parallel modes cannot match sync before width detection completes.
// - Words are ignored until sync; the sync position sets word alignment.
// - Sync pattern is 0xAA995566, sent by the source and matched here.
// - After alignment each word is a packet header or a payload word.
// - Header 0x30022001 writes one word to the watchdog timeout register.
// - Header 0x30020001 writes one word to the warm-boot start address.
// - Header 0x30008001 writes a command; low five bits select, zero is null.
// - Command 00111 clears the running CRC accumulator.
// - Header 0x30002001 writes one word to the frame select register.
// - Configuration memory is addressed only in whole, equal-length frames.
// - A CRC register write is compared with the computed CRC; mismatch flags error.
`ifndef CFSF_DEFS_SVH
`define CFSF_DEFS_SVH

`define CFSF_WIDTH_MARK     8'hbb
`define CFSF_CODE_X8        8'h11
`define CFSF_CODE_X16       8'h22
`define CFSF_CODE_X32       8'h44
`define CFSF_SYNC_WORD      32'haa995566
`define CFSF_HDR_TIMER      32'h30022001
`define CFSF_HDR_WBOOT      32'h30020001
`define CFSF_HDR_CMD        32'h30008001
`define CFSF_HDR_FRAME      32'h30002001
`define CFSF_HDR_CRC        32'h30000001
`define CFSF_HDR_NOOP       32'h20000000
`define CFSF_CMD_NULL       5'h00
`define CFSF_CMD_CRC_CLEAR  5'h07
`define CFSF_CMD_REPROG     5'h0f
`define CFSF_CRC_INIT       32'h00000000
`define CFSF_CRC_POLY       32'h1edc6f41
`define CFSF_FRAME_WORDS    8'd93

`endif

// file: cfsf_pkg.sv
// Types shared by the configuration stream front end.
// Assumes cfsf_defs.svh is on the include path.
`include "cfsf_defs.svh"

package cfsf_pkg;

    typedef enum logic [1:0] {
        CFSF_BUS_NONE = 2'h0,
        CFSF_BUS_X8   = 2'h1,
        CFSF_BUS_X16  = 2'h2,
        CFSF_BUS_X32  = 2'h3
    } cfsf_width_t;

    // Decoded registers, one strobe with the payload word.
    typedef struct packed {
        logic        timer_we;
        logic        wboot_we;
        logic        frame_we;
        logic        cmd_we;
        logic        crc_we;
        logic [31:0] data;
    } cfsf_wr_t;

endpackage : cfsf_pkg

// file: cfsf_width_det.sv
// Bus width detector: watches the low byte lane for the marker pair.
// Assumes one byte-lane sample per accepted transfer and a synchronous clear.
`include "cfsf_defs.svh"

module cfsf_width_det
    import cfsf_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        clear,
    input  wire logic        enable,
    // Sample
    input  wire logic        valid,
    input  wire logic [7:0]  low_lane,
    // Result
    output cfsf_width_t      width_r
);

    logic seen_mark_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_mark_r <= 1'b0;
            width_r     <= CFSF_BUS_NONE;
        end else if (clear) begin
            seen_mark_r <= 1'b0;
            width_r     <= CFSF_BUS_NONE;
        end else if (enable && valid && width_r == CFSF_BUS_NONE) begin
            // Only the low lane is examined here.
            if (seen_mark_r) begin
                seen_mark_r <= (low_lane == `CFSF_WIDTH_MARK);
                if (low_lane == `CFSF_CODE_X8) begin
                    width_r <= CFSF_BUS_X8;
                end else if (low_lane == `CFSF_CODE_X16) begin
                    width_r <= CFSF_BUS_X16;
                end else if (low_lane == `CFSF_CODE_X32) begin
                    width_r <= CFSF_BUS_X32;
                end
                // Any byte other than a code or another marker falls back to the hunt.
            end else begin
                seen_mark_r <= (low_lane == `CFSF_WIDTH_MARK);
            end
        end
    end

endmodule : cfsf_width_det

// file: cfsf_crc.sv
// Running CRC accumulator over payload words after alignment.
// Assumes clear and update are never needed in the same word.
`include "cfsf_defs.svh"

module cfsf_crc
    import cfsf_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        clear,
    input  wire logic        update,
    input  wire logic [31:0] word,
    // Result
    output logic [31:0]      crc_r
);

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ `CFSF_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_r <= `CFSF_CRC_INIT;
        end else if (clear) begin
            crc_r <= `CFSF_CRC_INIT;
        end else if (update) begin
            crc_r <= crc_step(crc_r, word);
        end
    end

endmodule : cfsf_crc

// file: cfsf_front_end.sv
// Configuration stream front end: width detection, sync hunt and type-1 packet decode.
// Assumes data words arrive on the configuration clock with a one-cycle valid strobe.
// Bytes on cfg_data arrive already restored to unswapped order by the pin logic.
`include "cfsf_defs.svh"

module cfsf_front_end
    import cfsf_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Mode and reprogram events
    input  wire logic        parallel_mode,
    input  wire logic        program_pulse,
    input  wire logic        jtag_reprogram_instr,
    // Configuration data port
    input  wire logic        cfg_valid,
    input  wire logic [31:0] cfg_data,
    // Status
    output cfsf_width_t      bus_width,
    output logic             synced_r,
    output logic             crc_error_r,
    output logic             internal_reprogram_cmd,
    output logic             crc_clear_cmd,
    // Registers
    output logic [31:0]      watchdog_timeout_r,
    output logic [31:0]      warm_boot_start_address_r,
    output logic [4:0]       command_code_r,
    output logic [31:0]      frame_select_register_r,
    output logic [7:0]       frame_word_cnt_r
);

    typedef enum logic [1:0] {
        ST_HUNT   = 2'b00,
        ST_HEADER = 2'b01,
        ST_DATA   = 2'b11
    } cfsf_state_t;

    cfsf_state_t state_r;
    cfsf_state_t state_nxt;
    cfsf_wr_t    target_r;
    cfsf_wr_t    wr;
    logic [31:0] crc_val;
    logic        width_clear;
    logic        width_ok;
    logic        payload;

    // A reprogram from the stream itself also clears the width lock.
    assign width_clear = program_pulse | jtag_reprogram_instr | internal_reprogram_cmd;
    assign width_ok    = !parallel_mode || (bus_width != CFSF_BUS_NONE);
    assign payload     = cfg_valid && state_r == ST_DATA;

    cfsf_width_det u_width (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clear    (width_clear),
        .enable   (parallel_mode),
        .valid    (cfg_valid),
        .low_lane (cfg_data[7:0]),
        .width_r  (bus_width)
    );

    always_comb begin
        state_nxt = state_r;
        if (cfg_valid) begin
            case (state_r)
                ST_HUNT: begin
                    // Sync needs the width first in parallel modes.
                    if (width_ok && cfg_data == `CFSF_SYNC_WORD) begin
                        state_nxt = ST_HEADER;
                    end
                end
                ST_HEADER: begin
                    if (cfg_data == `CFSF_HDR_TIMER || cfg_data == `CFSF_HDR_WBOOT ||
                        cfg_data == `CFSF_HDR_CMD || cfg_data == `CFSF_HDR_FRAME ||
                        cfg_data == `CFSF_HDR_CRC) begin
                        state_nxt = ST_DATA;
                    end
                end
                ST_DATA: begin
                    state_nxt = ST_HEADER;
                end
                default: begin
                    state_nxt = ST_HUNT;
                end
            endcase
        end
        if (width_clear) begin
            state_nxt = ST_HUNT;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_HUNT;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign synced_r = (state_r != ST_HUNT);

    // Latch which register the next payload word goes to.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_r <= '0;
        end else if (cfg_valid && state_r == ST_HEADER) begin
            target_r.timer_we <= (cfg_data == `CFSF_HDR_TIMER);
            target_r.wboot_we <= (cfg_data == `CFSF_HDR_WBOOT);
            target_r.cmd_we   <= (cfg_data == `CFSF_HDR_CMD);
            target_r.frame_we <= (cfg_data == `CFSF_HDR_FRAME);
            target_r.crc_we   <= (cfg_data == `CFSF_HDR_CRC);
            target_r.data     <= '0;
            // A no-operation header leaves every target clear.
        end
    end

    always_comb begin
        wr          = target_r;
        wr.data     = cfg_data;
        wr.timer_we = payload && target_r.timer_we;
        wr.wboot_we = payload && target_r.wboot_we;
        wr.cmd_we   = payload && target_r.cmd_we;
        wr.frame_we = payload && target_r.frame_we;
        wr.crc_we   = payload && target_r.crc_we;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_timeout_r        <= '0;
            warm_boot_start_address_r <= '0;
            frame_select_register_r   <= '0;
        end else begin
            // A zero timeout leaves the watchdog unused downstream.
            if (wr.timer_we) begin
                watchdog_timeout_r <= wr.data;
            end
            if (wr.wboot_we) begin
                warm_boot_start_address_r <= wr.data;
            end
            if (wr.frame_we) begin
                frame_select_register_r <= wr.data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            command_code_r <= `CFSF_CMD_NULL;
        end else if (wr.cmd_we) begin
            command_code_r <= wr.data[4:0];
        end
    end

    // Command strobes are one-cycle pulses on the payload word; null does nothing.
    assign crc_clear_cmd          = wr.cmd_we && wr.data[4:0] == `CFSF_CMD_CRC_CLEAR;
    assign internal_reprogram_cmd = wr.cmd_we && wr.data[4:0] == `CFSF_CMD_REPROG;

    // The CRC covers payload words other than the CRC value itself.
    cfsf_crc u_crc (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clear    (crc_clear_cmd),
        .update   (payload && !wr.crc_we && !crc_clear_cmd),
        .word     (cfg_data),
        .crc_r    (crc_val)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_error_r <= 1'b0;
        end else if (wr.crc_we && wr.data != crc_val) begin
            // A mismatch wins over a reprogram in the same cycle so no error is ever lost.
            crc_error_r <= 1'b1;
        end else if (width_clear) begin
            crc_error_r <= 1'b0;
        end
    end

    // Frame data loading sits downstream; a frame select restarts at the head of a frame.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_word_cnt_r <= '0;
        end else if (wr.frame_we) begin
            frame_word_cnt_r <= '0;
        end
    end

endmodule : cfsf_front_end

// file: cfsf_front_end_asserts.sv
// Concurrent checks on the ports of the configuration stream front end.
// Assumes one clock domain; bound to cfsf_front_end at the foot of this file.
`include "cfsf_defs.svh"
module cfsf_front_end_asserts
    import cfsf_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Stream and events
    input wire logic        parallel_mode,
    input wire logic        program_pulse,
    input wire logic        jtag_reprogram_instr,
    input wire logic        cfg_valid,
    input wire logic [31:0] cfg_data,
    // Results
    input wire cfsf_width_t bus_width,
    input wire logic        synced_r,
    input wire logic        crc_error_r,
    input wire logic        internal_reprogram_cmd,
    input wire logic        crc_clear_cmd,
    input wire logic [31:0] watchdog_timeout_r,
    input wire logic [31:0] warm_boot_start_address_r,
    input wire logic [4:0]  command_code_r,
    input wire logic [31:0] frame_select_register_r,
    input wire logic [7:0]  frame_word_cnt_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mark_r;
    logic pair;
    // Only a marker taken in the cycle just before counts, so gaps never pair up.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mark_r <= 1'b0;
        end else begin
            mark_r <= cfg_valid && parallel_mode && bus_width == CFSF_BUS_NONE
                      && cfg_data[7:0] == `CFSF_WIDTH_MARK;
        end
    end
    assign pair = mark_r && cfg_valid && parallel_mode && bus_width == CFSF_BUS_NONE
                  && !program_pulse && !jtag_reprogram_instr;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_SERIAL: assert property (!parallel_mode && bus_width == CFSF_BUS_NONE
        |=> bus_width == CFSF_BUS_NONE) else $error("width in serial mode");
    AST_X8: assert property (pair && cfg_data[7:0] == 8'h11
        |=> bus_width == CFSF_BUS_X8) else $error("x8 missed");
    AST_X16: assert property (pair && cfg_data[7:0] == 8'h22
        |=> bus_width == CFSF_BUS_X16) else $error("x16 missed");
    AST_X32: assert property (pair && cfg_data[7:0] == 8'h44
        |=> bus_width == CFSF_BUS_X32) else $error("x32 missed");
    AST_BAD: assert property (pair && !(cfg_data[7:0] inside {8'h11, 8'h22, 8'h44})
        |=> bus_width == CFSF_BUS_NONE) else $error("bad code taken");
    AST_HOLD: assert property (bus_width != CFSF_BUS_NONE && !program_pulse
        && !jtag_reprogram_instr && !internal_reprogram_cmd |=> $stable(bus_width))
        else $error("width moved");
    AST_NEEDW: assert property (parallel_mode && bus_width == CFSF_BUS_NONE && !synced_r
        |=> !synced_r) else $error("sync before width");
    AST_SYNC: assert property ($rose(synced_r) |-> $past(cfg_valid)
        && $past(cfg_data) == `CFSF_SYNC_WORD) else $error("sync without word");
    AST_WBOOT: assert property (synced_r && cfg_valid && cfg_data == `CFSF_HDR_WBOOT
        ##1 cfg_valid |=> warm_boot_start_address_r == $past(cfg_data)) else $error("wboot");
    AST_FRAME: assert property (synced_r && cfg_valid && cfg_data == `CFSF_HDR_FRAME
        ##1 cfg_valid |=> frame_select_register_r == $past(cfg_data)) else $error("frame");
    AST_CLR: assert property (crc_clear_cmd |-> cfg_valid && synced_r
        && cfg_data[4:0] == `CFSF_CMD_CRC_CLEAR) else $error("crc clear");
endmodule : cfsf_front_end_asserts
bind cfsf_front_end cfsf_front_end_asserts i_chk (.*);

// file: cfsf_cfg_source.sv
// Model of the configuration source: host or flash feeding words to the front end.
// Assumes the bench calls its tasks one at a time.
`include "cfsf_defs.svh"
module cfsf_cfg_source (
    // Clock
    input wire logic         core_clk,
    // Stream
    output var logic         cfg_valid,
    output var logic [31:0]  cfg_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cfg_valid = 1'b0;
        cfg_data  = 32'h0;
    end
    // Each byte sits bit-reversed on the pins; the pin stage ahead of the port mirrors it back.
    function automatic logic [31:0] mirror(input logic [31:0] w);
        logic [31:0] r;
        for (int b = 0; b < 32; b++) r[b] = w[(b & ~7) + 7 - (b & 7)];
        return r;
    endfunction : mirror
    task automatic send(input logic [31:0] w);
        logic [31:0] pins;
        @(posedge core_clk);
        #1;
        pins      = mirror(w);
        cfg_valid = 1'b1;
        cfg_data  = mirror(pins);
    endtask : send
    // An idle bus shows the inverse of the last word, so stale data never looks fresh.
    task automatic idle();
        @(posedge core_clk);
        #1;
        cfg_valid = 1'b0;
        cfg_data  = ~cfg_data;
    endtask : idle
    function automatic logic [31:0] pre_word(int i, logic [7:0] code, logic [23:0] junk);
        if (i == 16) return {junk, `CFSF_WIDTH_MARK};
        if (i == 17) return {junk, code};
        if (i < 20) return 32'hffffffff;
        return `CFSF_SYNC_WORD;
    endfunction : pre_word
endmodule : cfsf_cfg_source

// file: tb_top.sv
// Self-checking bench for the configuration stream front end.
// Assumes the source model drives the stream and the checker is bound.
`include "cfsf_defs.svh"
module tb_top
    import cfsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        parallel_mode = 1'b1;
    logic        program_pulse = 1'b0;
    logic        jtag_reprogram_instr = 1'b0;
    logic        cfg_valid;
    logic [31:0] cfg_data;
    cfsf_width_t bus_width;
    logic        synced_r, crc_error_r, internal_reprogram_cmd, crc_clear_cmd;
    logic [31:0] watchdog_timeout_r, warm_boot_start_address_r, frame_select_register_r;
    logic [4:0]  command_code_r;
    logic [7:0]  frame_word_cnt_r;
    int          miscompares = 0;
    int          n_tests = 0;
    int          m_w = 0, m_bb = 0, m_sync = 0, m_pend = 0, m_err = 0;
    logic [31:0] m_wd = '0, m_wb = '0, m_fr = '0, rnd = 32'h1e92;
    logic [31:0] m_crc = `CFSF_CRC_INIT;
    logic [4:0]  m_cmd = '0;
    always #25 core_clk = ~core_clk;
    cfsf_front_end i_dut (.*);
    cfsf_cfg_source i_src (.*);
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : xs
    // Reference CRC, most significant bit first, over one payload word.
    function automatic logic [31:0] crc_ref(logic [31:0] c, logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `CFSF_CRC_POLY : 32'h0);
        end
        return c;
    endfunction : crc_ref
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmp_all();
        chk(32'(bus_width), m_w);
        chk(32'(synced_r), m_sync);
        chk(watchdog_timeout_r, m_wd);
        chk(warm_boot_start_address_r, m_wb);
        chk(32'(command_code_r), 32'(m_cmd));
        chk(frame_select_register_r, m_fr);
        chk({crc_error_r, frame_word_cnt_r}, {m_err[0], 8'h00});
    endtask : cmp_all
    // Results of the previous word are compared once the edge that took it has landed.
    task automatic put(logic [31:0] w);
        logic clr;
        logic rep;
        clr = m_pend == 3 && w[4:0] == `CFSF_CMD_CRC_CLEAR;
        rep = m_pend == 3 && w[4:0] == `CFSF_CMD_REPROG;
        i_src.send(w);
        // The command strobes follow the word combinationally, so let them settle first.
        #1;
        cmp_all();
        chk({crc_clear_cmd, internal_reprogram_cmd}, {clr, rep});
        if (!m_sync) begin
            if (parallel_mode && m_w == 0) begin
                if (m_bb) m_w = w[7:0] == 8'h11 ? 1 : w[7:0] == 8'h22 ? 2 : w[7:0] == 8'h44 ? 3 : 0;
                m_bb = w[7:0] == 8'hbb;
            end else m_sync = w == `CFSF_SYNC_WORD;
        end else begin
            case (m_pend)
                1: m_wd = w;
                2: m_wb = w;
                3: m_cmd = w[4:0];
                4: m_fr = w;
                5: if (w != m_crc) m_err = 1;
                default: ;
            endcase
            if (clr) m_crc = `CFSF_CRC_INIT;
            else if (m_pend inside {[1:4]}) m_crc = crc_ref(m_crc, w);
            m_pend = m_pend ? 0 : w == `CFSF_HDR_TIMER ? 1 : w == `CFSF_HDR_WBOOT ? 2 :
                     w == `CFSF_HDR_CMD ? 3 : w == `CFSF_HDR_FRAME ? 4 : w == `CFSF_HDR_CRC ? 5 : 0;
            if (rep) {m_w, m_bb, m_sync, m_err} = '0;
        end
    endtask : put
    task automatic reprog(bit jtag);
        i_src.idle();
        cmp_all();
        if (jtag) jtag_reprogram_instr = 1'b1;
        else program_pulse = 1'b1;
        @(posedge core_clk);
        #1;
        program_pulse = 1'b0;
        jtag_reprogram_instr = 1'b0;
        {m_w, m_bb, m_sync, m_pend, m_err} = '0;
        cmp_all();
    endtask : reprog
    task automatic stream(logic [7:0] code, bit bad);
        logic [31:0] pay;
        for (int i = 0; i < 21; i++) put(i_src.pre_word(i, code, 24'(xs())));
        pay = xs();
        put(`CFSF_HDR_NOOP);
        put(`CFSF_HDR_TIMER);
        put(xs());
        put(`CFSF_HDR_WBOOT);
        put(xs());
        put(`CFSF_HDR_CMD);
        put({pay[31:5], 5'h00});
        put(`CFSF_HDR_CMD);
        put({pay[31:5], 5'h07});
        put(`CFSF_HDR_FRAME);
        put(xs());
        put(`CFSF_HDR_CRC);
        put(bad ? ~m_crc : m_crc);
        put(32'h000000bb);
        put(32'h00000011);
        put(`CFSF_HDR_CMD);
        put({pay[31:5], `CFSF_CMD_REPROG});
    endtask : stream
    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        put(`CFSF_SYNC_WORD);
        put(32'h000000bb);
        put(32'h5a5a5a33);
        for (int k = 0; k < 4; k++) begin
            parallel_mode = k < 3;
            stream(k == 0 ? 8'h11 : k == 1 ? 8'h22 : 8'h44, k[0]);
            reprog(k[0]);
        end
        stop_test();
    end
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule : tb_top
